// ==== core/tp_mau_status_control.v ====
// status and control logic of a twisted-pair attachment unit
//
// Decided for this implementation: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "tp_mau_defs.vh"

module tp_mau_status_control #(
    parameter integer STRETCH_CYCLES    = `STRETCH_CYCLES,
    parameter integer UNJAB_CYCLES      = `UNJAB_CYCLES,
    parameter integer JABBER_CYCLES     = `JABBER_CYCLES,
    parameter integer LINK_LOSS_CYCLES  = `LINK_LOSS_CYCLES,
    parameter integer LINK_PULSE_CYCLES = `LINK_PULSE_CYCLES,
    parameter integer LINK_PASS_PULSES  = `LINK_PASS_PULSES,
    parameter integer TW                = `TIMER_W
) (
    input  wire              aclk,
    input  wire              aresetn,
    input  wire [`ADDR_W-1:0] awaddr,
    input  wire [2:0]        awprot,
    input  wire              awvalid,
    output reg               awready,
    input  wire [31:0]       wdata,
    input  wire [3:0]        wstrb,
    input  wire              wvalid,
    output reg               wready,
    output reg  [1:0]        bresp,
    output reg               bvalid,
    input  wire              bready,
    input  wire [`ADDR_W-1:0] araddr,
    input  wire [2:0]        arprot,
    input  wire              arvalid,
    output reg               arready,
    output reg  [31:0]       rdata,
    output reg  [1:0]        rresp,
    output reg               rvalid,
    input  wire              rready,
    output reg               irq,
    input  wire              power_down_reset_n,
    input  wire              do_active,
    input  wire              do_data,
    input  wire              rx_active,
    input  wire              rx_data,
    input  wire              rx_link_pulse,
    input  wire              rx_frame_end,
    input  wire              rx_pulse_inverted,
    input  wire              heartbeat_active,
    input  wire              low_threshold_select_n,
    input  wire              link_state_pin_in,
    output reg               link_state_pin_out,
    output reg               link_state_pin_oe,
    input  wire              polarity_state_pin_in,
    output reg               polarity_state_pin_out,
    output reg               polarity_state_pin_oe,
    output reg               col_n,
    output reg               receive_indicator_n,
    output reg               ci_pattern,
    output reg               tx_enable,
    output reg               tx_data,
    output reg               tx_link_pulse,
    output reg               di_enable,
    output reg               di_data
);

    localparam [TW-1:0] TONE       = {{(TW-1){1'b0}}, 1'b1};
    localparam [TW-1:0] JAB_LAST   = JABBER_CYCLES[TW-1:0] - TONE;
    localparam [TW-1:0] BEAT_LOAD  = LINK_PULSE_CYCLES[TW-1:0] - TONE;
    localparam [`PCNT_W-1:0] PASS_N = LINK_PASS_PULSES[`PCNT_W-1:0];
    localparam [`PCNT_W-1:0] PONE   = {{(`PCNT_W-1){1'b0}}, 1'b1};
    // one-hot link states
    localparam [1:0] LS_FAIL = 2'h1;
    localparam [1:0] LS_PASS = 2'h2;

    // unit logic clears on bus reset or power-down
    wire unit_rst = !aresetn || !power_down_reset_n;

    reg  [1:0]          link_st;
    reg  [`PCNT_W-1:0]  pulse_run;
    reg  [TW-1:0]       jab_cnt;
    reg  [TW-1:0]       beat_cnt;
    reg                 jabber;
    reg                 pol_inv;
    reg                 strap_taken;
    reg                 link_strap_off;
    reg                 pol_strap_off;
    reg                 collision_d;
    reg  [1:0]          control;
    reg  [`EV_W-1:0]    status;
    reg  [`EV_W-1:0]    irq_enable;
    reg                 aw_hold;
    reg                 w_hold;
    reg  [`ADDR_W-1:0]  aw_addr_q;
    reg  [31:0]         w_data_q;
    reg  [3:0]          w_strb_q;
    reg  [`EV_W-1:0]    next_status;
    reg  [31:0]         next_rdata;
    reg                 next_rerr;

    wire unjab_busy;
    wire col_busy;
    wire rcv_busy;
    wire link_alive;

    // link test runs unless strapped off or turned off by software
    wire link_test_on = !link_strap_off && control[`CTL_LINK_TEST];
    wire link_ok      = (link_st == LS_PASS);
    wire functional   = link_ok || !link_test_on;
    wire pol_fix_on   = !pol_strap_off && control[`CTL_POL_FIX];
    // paths are gated in link fail
    wire receiving    = rx_active && functional;
    wire collision    = do_active && rx_active && functional;
    wire col_cause    = collision || jabber;
    wire tx_go        = do_active && functional && !jabber;
    wire pol_seen     = (rx_link_pulse || rx_frame_end)
                        && rx_pulse_inverted;
    wire pol_event    = pol_seen && pol_fix_on && !pol_inv;
    wire fail_event   = link_ok && link_test_on && !link_alive;
    wire pass_event   = !link_ok && (rx_active ||
                        (rx_link_pulse && pulse_run == PASS_N - PONE));
    wire jab_event    = do_active && !jabber && jab_cnt == JAB_LAST;
    wire wr_fire      = aw_hold && w_hold && !bvalid;
    wire [`ADDR_W-1:0] wr_addr = {aw_addr_q[`ADDR_W-1:2], 2'h0};
    wire [`ADDR_W-1:0] rd_addr = {araddr[`ADDR_W-1:2], 2'h0};

    // retriggered timers for unjab, both stretches and link loss
    stretch_timer #(.CYCLES(UNJAB_CYCLES), .W(TW)) unjab_timer (
        .clk     (aclk),
        .clear   (unit_rst),
        .trigger (do_active),
        .busy    (unjab_busy)
    );

    stretch_timer #(.CYCLES(STRETCH_CYCLES), .W(TW)) col_timer (
        .clk     (aclk),
        .clear   (unit_rst),
        .trigger (col_cause),
        .busy    (col_busy)
    );

    stretch_timer #(.CYCLES(STRETCH_CYCLES), .W(TW)) rcv_timer (
        .clk     (aclk),
        .clear   (unit_rst),
        .trigger (receiving || collision),
        .busy    (rcv_busy)
    );

    stretch_timer #(.CYCLES(LINK_LOSS_CYCLES), .W(TW)) link_timer (
        .clk     (aclk),
        .clear   (unit_rst),
        .trigger (rx_link_pulse || rx_active),
        .busy    (link_alive)
    );

    // straps are read one cycle after release, before any pin drives
    always @(posedge aclk) begin
        if (unit_rst) begin
            strap_taken    <= 1'b0;
            link_strap_off <= 1'b0;
            pol_strap_off  <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken    <= 1'b1;
            link_strap_off <= !link_state_pin_in;
            pol_strap_off  <= !polarity_state_pin_in;
        end
    end

    // link integrity: fail until data or enough consecutive pulses
    always @(posedge aclk) begin
        if (unit_rst) begin
            link_st   <= LS_FAIL;
            pulse_run <= {`PCNT_W{1'b0}};
        end else begin
            case (link_st)
                LS_FAIL: begin
                    if (pass_event) begin
                        link_st   <= LS_PASS;
                        pulse_run <= {`PCNT_W{1'b0}};
                    end else if (rx_link_pulse) begin
                        pulse_run <= pulse_run + PONE;
                    end else if (!link_alive) begin
                        pulse_run <= {`PCNT_W{1'b0}};
                    end
                end
                LS_PASS: begin
                    if (fail_event) begin
                        link_st <= LS_FAIL;
                    end
                end
                default: begin
                    link_st <= LS_FAIL;
                end
            endcase
        end
    end

    // jabber on overlong DO, left only after a full unjab idle gap
    always @(posedge aclk) begin
        if (unit_rst) begin
            jab_cnt <= {TW{1'b0}};
            jabber  <= 1'b0;
        end else begin
            if (!do_active) begin
                jab_cnt <= {TW{1'b0}};
            end else if (jab_cnt != JAB_LAST) begin
                jab_cnt <= jab_cnt + TONE;
            end
            if (jab_event) begin
                jabber <= 1'b1;
            end else if (jabber && !unjab_busy) begin
                jabber <= 1'b0;
            end
        end
    end

    // correction stays set until reset; no way back in service
    always @(posedge aclk) begin
        if (unit_rst) begin
            pol_inv <= 1'b0;
        end else if (pol_event && functional) begin
            pol_inv <= 1'b1;
        end
    end

    // beat pulses while the transmit pair is idle, link state ignored
    always @(posedge aclk) begin
        if (unit_rst || tx_go) begin
            beat_cnt      <= BEAT_LOAD;
            tx_link_pulse <= 1'b0;
        end else if (beat_cnt == {TW{1'b0}}) begin
            beat_cnt      <= BEAT_LOAD;
            tx_link_pulse <= 1'b1;
        end else begin
            beat_cnt      <= beat_cnt - TONE;
            tx_link_pulse <= 1'b0;
        end
    end

    // registered pins; all idle in power-down
    always @(posedge aclk) begin
        if (unit_rst) begin
            col_n                  <= 1'b1;
            receive_indicator_n    <= 1'b1;
            ci_pattern             <= 1'b0;
            tx_enable              <= 1'b0;
            tx_data                <= 1'b0;
            di_enable              <= 1'b0;
            di_data                <= 1'b0;
            link_state_pin_out     <= 1'b0;
            link_state_pin_oe      <= 1'b0;
            polarity_state_pin_out <= 1'b0;
            polarity_state_pin_oe  <= 1'b0;
            collision_d            <= 1'b0;
        end else begin
            col_n <= !(col_busy && !heartbeat_active);
            receive_indicator_n <= !rcv_busy;
            ci_pattern  <= col_cause;
            tx_enable   <= tx_go;
            tx_data     <= tx_go && do_data;
            // receive wins the DI pair; otherwise DO loops back
            di_enable   <= receiving || tx_go;
            di_data     <= receiving ? (rx_data ^ pol_inv)
                                     : (tx_go && do_data);
            link_state_pin_out     <= 1'b0;
            link_state_pin_oe      <= strap_taken && functional;
            polarity_state_pin_out <= 1'b0;
            polarity_state_pin_oe  <= strap_taken && !pol_inv;
            collision_d            <= collision;
        end
    end

    // sticky events; a new event beats a clear in the same cycle
    always @* begin
        next_status = status;
        if (wr_fire && wr_addr == `REG_IRQ_CLEAR && w_strb_q[0]) begin
            next_status = status & ~w_data_q[`EV_W-1:0];
        end
        next_status[`EV_COLLISION] = next_status[`EV_COLLISION]
                                     | (collision && !collision_d);
        next_status[`EV_JABBER]    = next_status[`EV_JABBER] | jab_event;
        next_status[`EV_LINK_FAIL] = next_status[`EV_LINK_FAIL] | fail_event;
        next_status[`EV_LINK_PASS] = next_status[`EV_LINK_PASS] | pass_event;
        next_status[`EV_POL_REVERSED] = next_status[`EV_POL_REVERSED]
                                        | (pol_event && functional);
    end

    // software registers and interrupt level
    always @(posedge aclk) begin
        if (!aresetn) begin
            status     <= {`EV_W{1'b0}};
            irq_enable <= {`EV_W{1'b0}};
            control    <= `CONTROL_RESET;
            irq        <= 1'b0;
        end else begin
            status <= power_down_reset_n ? next_status : {`EV_W{1'b0}};
            irq    <= |(next_status & irq_enable) && power_down_reset_n;
            if (wr_fire && w_strb_q[0]) begin
                if (wr_addr == `REG_IRQ_ENABLE) begin
                    irq_enable <= w_data_q[`EV_W-1:0];
                end
                if (wr_addr == `REG_CONTROL) begin
                    control <= w_data_q[1:0];
                end
            end
        end
    end

    // write channel: address and data taken in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b0;
            wready    <= 1'b0;
            aw_hold   <= 1'b0;
            w_hold    <= 1'b0;
            aw_addr_q <= {`ADDR_W{1'b0}};
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
            bvalid    <= 1'b0;
            bresp     <= `RESP_OKAY;
        end else begin
            if (!aw_hold && !awready && !bvalid) begin
                awready <= 1'b1;
            end
            if (!w_hold && !wready && !bvalid) begin
                wready <= 1'b1;
            end
            if (awvalid && awready) begin
                aw_hold   <= 1'b1;
                aw_addr_q <= awaddr;
                awready   <= 1'b0;
            end
            if (wvalid && wready) begin
                w_hold   <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
                wready   <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold <= 1'b0;
                w_hold  <= 1'b0;
                bvalid  <= 1'b1;
                bresp   <= (wr_addr == `REG_IRQ_ENABLE ||
                            wr_addr == `REG_IRQ_CLEAR ||
                            wr_addr == `REG_CONTROL) ? `RESP_OKAY
                                                     : `RESP_SLVERR;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // read mux; unmapped and write-only offsets read zero with error
    always @* begin
        next_rdata = 32'h0;
        next_rerr  = 1'b0;
        case (rd_addr)
            `REG_STATUS:     next_rdata[`EV_W-1:0] = status;
            `REG_IRQ_ENABLE: next_rdata[`EV_W-1:0] = irq_enable;
            `REG_CONTROL:    next_rdata[1:0] = control;
            `REG_STATE:      next_rdata[7:0] = {low_threshold_select_n,
                                 pol_strap_off, link_strap_off,
                                 !receive_indicator_n, !col_n, pol_inv,
                                 jabber, functional};
            default:         next_rerr = 1'b1;
        endcase
    end

    // read channel, answer one cycle after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `RESP_OKAY;
        end else begin
            if (!arready && !rvalid) begin
                arready <= 1'b1;
            end
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= next_rdata;
                rresp   <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

endmodule // tp_mau_status_control

// ==== core/tp_mau_defs.vh ====
// constants for the twisted-pair status and control block
`ifndef TP_MAU_DEFS_VH
`define TP_MAU_DEFS_VH

// clock and timing, times in ms as chosen inside each window
`define CLK_HZ           25000000
`define CLK_PER_MS       (`CLK_HZ / 1000)
`define STRETCH_MS       40
`define STRETCH_CYCLES   (`CLK_PER_MS * `STRETCH_MS)
`define UNJAB_MS         500
`define UNJAB_CYCLES     (`CLK_PER_MS * `UNJAB_MS)
`define JABBER_MS        50
`define JABBER_CYCLES    (`CLK_PER_MS * `JABBER_MS)
`define LINK_LOSS_MS     100
`define LINK_LOSS_CYCLES (`CLK_PER_MS * `LINK_LOSS_MS)
`define LINK_PULSE_MS    16
`define LINK_PULSE_CYCLES (`CLK_PER_MS * `LINK_PULSE_MS)
`define LINK_PASS_PULSES 6
`define TIMER_W          24
`define PCNT_W           3

// register map, byte addresses
`define ADDR_W           8
`define REG_STATUS       8'h00
`define REG_IRQ_ENABLE   8'h04
`define REG_IRQ_CLEAR    8'h08
`define REG_CONTROL      8'h0C
`define REG_STATE        8'h10

// field positions and reset values
`define EV_COLLISION     0
`define EV_JABBER        1
`define EV_LINK_FAIL     2
`define EV_LINK_PASS     3
`define EV_POL_REVERSED  4
`define EV_W             5
`define CTL_LINK_TEST    0
`define CTL_POL_FIX      1
`define CONTROL_RESET    2'h3
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

// ==== core/stretch_timer.v ====
// retriggerable hold timer that stretches an activity level
`timescale 1ns/1ns

module stretch_timer #(
    parameter integer CYCLES = 1000,
    parameter integer W      = 24
) (
    input  wire         clk,
    input  wire         clear,
    input  wire         trigger,
    output reg          busy
);

    localparam [W-1:0] ONE  = {{(W-1){1'b0}}, 1'b1};
    localparam [W-1:0] LOAD = CYCLES[W-1:0] - ONE;

    reg [W-1:0]         count;

    // reload on activity, then run down; busy falls about CYCLES later
    always @(posedge clk) begin
        if (clear) begin
            count <= {W{1'b0}};
            busy  <= 1'b0;
        end else if (trigger) begin
            count <= LOAD;
            busy  <= 1'b1;
        end else if (count != {W{1'b0}}) begin
            count <= count - ONE;
            busy  <= (count != ONE);
        end else begin
            busy  <= 1'b0;
        end
    end

endmodule // stretch_timer

// ==== sim/mac_model.sv ====
// far-side controller model driving DO bursts on request
`timescale 1ns/1ns
module mac_model (
    input  wire       aclk,
    input  wire       go,
    input  wire [7:0] len,
    output reg        do_active = 1'b0,
    output reg        do_data = 1'b0
);
    reg [7:0] left = 8'h00;

    // burst of len cycles; data toggles so idle never shows a stale bit
    always @(posedge aclk) begin
        if (go)
            left <= len;
        else if (left != 8'h00)
            left <= left - 8'h01;
        do_active <= go || (left > 8'h01);
        do_data <= ~do_data;
    end
endmodule // mac_model

// ==== sim/tp_mau_monitor.sv ====
// port checker for the twisted-pair status and control block
`timescale 1ns/1ns
module tp_mau_monitor #(
    parameter integer JABBER_CYCLES     = 30,
    parameter integer LINK_PULSE_CYCLES = 16
) (
    input wire aclk,
    input wire aresetn,
    input wire awready,
    input wire wready,
    input wire bvalid,
    input wire arready,
    input wire rvalid,
    input wire power_down_reset_n,
    input wire do_active,
    input wire rx_active,
    input wire heartbeat_active,
    input wire link_state_pin_oe,
    input wire polarity_state_pin_oe,
    input wire col_n,
    input wire receive_indicator_n,
    input wire ci_pattern,
    input wire tx_enable,
    input wire tx_link_pulse,
    input wire di_enable
);
    integer do_run = 0;
    integer gap = 0;
    reg     pol_lost = 1'b0;

    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // length of the current DO burst; power-down restarts it
    always @(posedge aclk) begin
        if (!aresetn || !power_down_reset_n || !do_active)
            do_run <= 0;
        else if (do_run < 1000)
            do_run <= do_run + 1;
    end

    // idle time since the last beat; any DO activity may reload it
    always @(posedge aclk) begin
        if (!aresetn || !power_down_reset_n || tx_link_pulse
            || tx_enable || do_active)
            gap <= 0;
        else if (gap < 1000)
            gap <= gap + 1;
    end

    // reversal seen; a fall caused by power-down does not count
    always @(posedge aclk) begin
        if (!aresetn || !power_down_reset_n)
            pol_lost <= 1'b0;
        else if ($fell(polarity_state_pin_oe) && $past(power_down_reset_n)
            && $past(aresetn))
            pol_lost <= 1'b1;
    end

    AST_COL_RCV: assert property (
        (do_active && rx_active && link_state_pin_oe && power_down_reset_n
        && !heartbeat_active) |-> ##2 (!col_n && !receive_indicator_n))
        else $error("collision not shown on both indicators");
    AST_HB_MASK: assert property (
        heartbeat_active |=> col_n)
        else $error("collision shown during heartbeat");
    AST_COL_HOLD: assert property (
        $fell(do_active && rx_active) && link_state_pin_oe
        |=> (!col_n || $past(heartbeat_active)
        || !$past(power_down_reset_n))[*8])
        else $error("collision indicator not stretched");
    AST_JABBER: assert property (
        (do_run == JABBER_CYCLES + 2) && do_active && power_down_reset_n
        && !heartbeat_active |=> !col_n && ci_pattern)
        else $error("overlong DO did not jabber");
    AST_PD_QUIET: assert property (
        !power_down_reset_n |=> col_n && receive_indicator_n
        && !link_state_pin_oe && !polarity_state_pin_oe && !ci_pattern
        && !tx_enable && !di_enable)
        else $error("driver active in power-down");
    AST_POL_KEPT: assert property (
        pol_lost && power_down_reset_n |-> !polarity_state_pin_oe)
        else $error("polarity state not kept");
    AST_BEAT_GAP: assert property (
        gap <= LINK_PULSE_CYCLES + 3)
        else $error("link beat missing while idle");
    AST_ONE_WR: assert property (
        bvalid |-> !awready && !wready)
        else $error("write taken while response pending");
    AST_ONE_RD: assert property (
        rvalid |-> !arready)
        else $error("read taken while data pending");
endmodule // tp_mau_monitor

// ==== sim/tp_mau_status_control_test.sv ====
// self-checking bench for the twisted-pair status and control block
`timescale 1ns/1ns
`include "tp_mau_defs.vh"
module tp_mau_status_control_test;
    localparam integer STR = 20;
    reg         aclk = 1'b0, aresetn = 1'b0, go = 1'b0;
    reg   [7:0] awaddr = 8'h00, araddr = 8'h00, len = 8'h00;
    reg  [31:0] wdata = 32'h0, rv;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    reg         arvalid = 1'b0, rready = 1'b0, keep = 1'b0;
    reg         power_down_reset_n = 1'b1, rx_active = 1'b0;
    reg         rx_data = 1'b0, rx_link_pulse = 1'b0, rx_frame_end = 1'b0;
    reg         rx_pulse_inverted = 1'b0, heartbeat_active = 1'b0;
    reg         lnk_strap = 1'b0, pol_strap = 1'b0;
    reg   [3:0] bcnt = 4'h0;
    reg   [1:0] resp;
    integer     n_errors = 0, checks_done = 0, k, i;
    wire        awready, wready, bvalid, arready, rvalid, irq;
    wire        do_active, do_data, col_n, receive_indicator_n;
    wire  [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire        link_state_pin_in, link_state_pin_out, link_state_pin_oe;
    wire        polarity_state_pin_in, polarity_state_pin_out;
    wire        polarity_state_pin_oe, ci_pattern, tx_enable, tx_data;
    wire        tx_link_pulse, di_enable, di_data;
    wire  [2:0] awprot = 3'h0, arprot = 3'h0;
    wire  [3:0] wstrb = 4'hF;
    wire        low_threshold_select_n = 1'b1;

    // open-drain pins with pull-ups; a strap holds the wire low
    assign link_state_pin_in = !lnk_strap
        && !(link_state_pin_oe && !link_state_pin_out);
    assign polarity_state_pin_in = !pol_strap
        && !(polarity_state_pin_oe && !polarity_state_pin_out);

    tp_mau_status_control #(
        .STRETCH_CYCLES(STR), .UNJAB_CYCLES(50), .JABBER_CYCLES(30),
        .LINK_LOSS_CYCLES(40), .LINK_PULSE_CYCLES(16)
    ) u_tp_mau_status_control (.*);
    mac_model u_mac_model (.aclk(aclk), .go(go), .len(len),
        .do_active(do_active), .do_data(do_data));

    always #20 aclk = ~aclk;

    // far-end link beats every 10 cycles, well inside the loss time
    always @(posedge aclk) begin
        bcnt <= (bcnt == 4'h9) ? 4'h0 : bcnt + 4'h1;
        rx_link_pulse <= keep && (bcnt == 4'h0);
    end

    task final_report;
        begin
            $display("checks %0d errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("[FAIL] %s expected %h seen %h", n, e, g);
            end
        end
    endtask

    task tick(input integer n);
        repeat (n) @(posedge aclk);
    endtask

    task tmo(input reg got);
        if (!got) begin
            chk("bus answer", 1, 0);
            final_report;
        end
    endtask

    // write: address and data offered together, each dropped when taken
    task wr(input [7:0] a, input [31:0] d);
        reg got;
        begin
            got = 1'b0;
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            for (i = 0; i < 40 && !got; i = i + 1) begin
                @(posedge aclk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) begin
                    got = 1'b1;
                    resp = bresp;
                    bready <= 1'b0;
                end
            end
            tmo(got);
            @(posedge aclk);
        end
    endtask

    task rd(input [7:0] a);
        reg got;
        begin
            got = 1'b0;
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            for (i = 0; i < 40 && !got; i = i + 1) begin
                @(posedge aclk);
                if (arready) arvalid <= 1'b0;
                if (rvalid) begin
                    got = 1'b1;
                    rv = rdata;
                    resp = rresp;
                    rready <= 1'b0;
                end
            end
            tmo(got);
            @(posedge aclk);
        end
    endtask

    // one DO burst from the far-side model; inv_end sends an inverted frame end
    task burst(input [7:0] n);
        begin
            go <= 1'b1;
            len <= n;
            @(posedge aclk);
            go <= 1'b0;
        end
    endtask

    task inv_end;
        begin
            rx_pulse_inverted <= 1'b1;
            rx_frame_end <= 1'b1;
            @(posedge aclk);
            rx_frame_end <= 1'b0;
        end
    endtask

    initial begin
        tick(3);
        chk("col_n", 1, col_n);
        chk("link_oe", 0, link_state_pin_oe);
        aresetn <= 1'b1;
        rd(`REG_CONTROL);
        chk("control", `CONTROL_RESET, rv);
        rd(8'h20);
        chk("unmapped", `RESP_SLVERR, resp);
        wr(`REG_STATUS, 32'h1F);
        chk("ro write", `RESP_SLVERR, resp);
        keep <= 1'b1;
        tick(80);
        chk("link_oe", 1, link_state_pin_oe);
        $display("test registers and link pass done");
        wr(`REG_IRQ_ENABLE, 32'h1);
        rx_active <= 1'b1;
        rx_data <= 1'b1;
        burst(8'h0F);
        tick(3);
        chk("col_n", 0, col_n);
        chk("rcv_n", 0, receive_indicator_n);
        chk("tx_en", 1, tx_enable);
        chk("tx_data", !do_data, tx_data);
        chk("irq", 1, irq);
        tick(14);
        rx_active <= 1'b0;
        tick(10);
        chk("col_n", 0, col_n);
        chk("rcv_n", 0, receive_indicator_n);
        tick(STR);
        chk("col_n", 1, col_n);
        chk("rcv_n", 1, receive_indicator_n);
        wr(`REG_IRQ_CLEAR, 32'h1);
        tick(2);
        chk("irq", 0, irq);
        heartbeat_active <= 1'b1;
        rx_active <= 1'b1;
        burst(8'h0A);
        tick(3);
        chk("col_n", 1, col_n);
        tick(10);
        heartbeat_active <= 1'b0;
        tick(45);
        chk("di_en", 1, di_enable);
        chk("di", 1, di_data);
        chk("pol_oe", 1, polarity_state_pin_oe);
        inv_end;
        tick(3);
        chk("pol_oe", 0, polarity_state_pin_oe);
        chk("di", 0, di_data);
        rx_active <= 1'b0;
        rx_pulse_inverted <= 1'b0;
        $display("test collision and polarity done");
        tick(STR + 5);
        wr(`REG_IRQ_CLEAR, 32'h1F);
        burst(8'd40);
        tick(42);
        chk("ci", 1, ci_pattern);
        chk("col_n", 0, col_n);
        chk("irq masked", 0, irq);
        tick(20);
        chk("ci", 1, ci_pattern);
        tick(40);
        chk("ci", 0, ci_pattern);
        keep <= 1'b0;
        tick(60);
        chk("link_oe", 0, link_state_pin_oe);
        burst(8'h0A);
        tick(3);
        chk("tx_en", 0, tx_enable);
        tick(10);
        k = 0;
        for (i = 0; i < 40; i = i + 1) begin
            @(posedge aclk);
            k = k + tx_link_pulse;
        end
        chk("beats", 1, k >= 2);
        $display("test jabber and link fail done");
        keep <= 1'b1;
        tick(80);
        power_down_reset_n <= 1'b0;
        tick(3);
        chk("link_oe", 0, link_state_pin_oe);
        rd(`REG_STATUS);
        chk("status", 0, rv);
        power_down_reset_n <= 1'b1;
        tick(5);
        chk("pol_oe", 1, polarity_state_pin_oe);
        lnk_strap <= 1'b1;
        pol_strap <= 1'b1;
        keep <= 1'b0;
        aresetn <= 1'b0;
        tick(3);
        aresetn <= 1'b1;
        tick(5);
        rx_active <= 1'b1;
        inv_end;
        burst(8'h08);
        tick(3);
        chk("col_n", 0, col_n);
        chk("di", 1, di_data);
        rd(`REG_STATE);
        chk("state", 32'hF9, rv);
        rx_active <= 1'b0;
        $display("test power-down and straps done");
        final_report;
    end
endmodule // tp_mau_status_control_test

bind tp_mau_status_control tp_mau_monitor #(
    .JABBER_CYCLES(JABBER_CYCLES), .LINK_PULSE_CYCLES(LINK_PULSE_CYCLES)
) u_tp_mau_monitor (.*);
